// >>> rtl/charger_pkg.sv
// Package holding command codes, field positions, reset values and timing for the command bank
package charger_pkg;

  // ************************************************************
  // Command codes
  // ************************************************************
  localparam logic [7:0] MODE_COMMAND          = 8'h12; // Mode word
  localparam logic [7:0] STATUS_COMMAND        = 8'h13; // Status word
  localparam logic [7:0] AMPS_REQUEST_COMMAND  = 8'h14; // Current request
  localparam logic [7:0] VOLTS_REQUEST_COMMAND = 8'h15; // Voltage request
  localparam logic [7:0] ALARM_COMMAND         = 8'h16; // Alarm warning

  // ************************************************************
  // Mode word fields
  // ************************************************************
  localparam int MODE_INHIBIT_BIT       = 0;  // Inhibit charging
  localparam int MODE_POLL_BIT          = 1;  // Polling, ignored
  localparam int MODE_POR_BIT           = 2;  // Reset controller fields
  localparam int MODE_ZERO_BIT          = 3;  // zero_charge_values

  // ************************************************************
  // Status word fields
  // ************************************************************
  localparam int ST_INHIBIT_BIT         = 0;
  localparam int ST_MASTER_BIT          = 1;
  localparam int ST_VUNREG_BIT          = 2;
  localparam int ST_AUNREG_BIT          = 3;
  localparam int ST_LEVEL_LO            = 4;
  localparam int ST_LEVEL_HI            = 5;
  localparam logic [1:0] ST_LEVEL_VAL   = 2'h1; // Battery controlled
  localparam int ST_AMPS_OR_BIT         = 6;
  localparam int ST_VOLTS_OR_BIT        = 7;
  localparam int ST_SENSOR_LO           = 8;  // Bits 11:8 sensor decode
  localparam int ST_ALARM_INH_BIT       = 12;
  localparam int ST_RATIO_BIT           = 13;
  localparam int ST_BATTERY_BIT         = 14;
  localparam int ST_ADAPTER_BIT         = 15;

  // ************************************************************
  // Alarm word and request values
  // ************************************************************
  localparam int ALARM_STOP_LO          = 12; // Bits 15:12 stop charging
  localparam logic [15:0] REQ_ALL_ONES  = 16'hffff;
  localparam logic [15:0] WORD_RESET    = 16'h0000;

  // ************************************************************
  // Timing: pairing window of three minutes
  // ************************************************************
  localparam longint PAIR_WINDOW_S      = 180;
  localparam longint CLOCK_HZ           = 100_000_000;
  localparam longint PAIR_WINDOW_CYC    = PAIR_WINDOW_S * CLOCK_HZ;

  // Charger controller states
  typedef enum logic [1:0] {
    CHG_NONE    = 2'b00,
    CHG_WAIT    = 2'b01,
    CHG_RUN     = 2'b10
  } chg_state_t;

endpackage

// >>> rtl/request_store.sv
// Two-word store for the accepted current and voltage values, registered read data
`timescale 1ns/1ps
`default_nettype none
module request_store (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Write port
  input  wire logic        wr_en,
  input  wire logic        wr_sel,
  input  wire logic [15:0] wr_data,
  input  wire logic        clr,
  // Read port
  input  wire logic        rd_sel,
  output var  logic [15:0] rd_data
);
  import charger_pkg::*;

  logic [15:0] mem_r [2]; // Entry 0 current, entry 1 voltage

  // ************************************************************
  // Storage, cleared by reset or zeroing
  // ************************************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mem_r[0] <= WORD_RESET;
      mem_r[1] <= WORD_RESET;
      rd_data  <= WORD_RESET;
    end else begin
      if (clr) begin
        mem_r[0] <= WORD_RESET;
        mem_r[1] <= WORD_RESET;
      end else if (wr_en) begin
        mem_r[wr_sel] <= wr_data;
      end
      rd_data <= mem_r[rd_sel];
    end
  end
endmodule
`default_nettype wire

// >>> rtl/charger_command_word_bank.sv
// Command word bank of a battery charger: mode, status, request and alarm words
`timescale 1ns/1ps
`default_nettype none
module charger_command_word_bank #(
  parameter longint PAIR_WINDOW = charger_pkg::PAIR_WINDOW_CYC
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  // Command port from the bus protocol engine
  input  wire logic                     cmd_wr,       // Write word pulse
  input  wire logic                     cmd_rd,       // Read word start pulse
  input  wire logic [7:0]               cmd_code,
  input  wire logic [15:0]              cmd_wdata,
  input  wire logic                     ara_rd,       // Alert response read done
  output logic                          cmd_ack,      // Accepted pulse
  output logic                          cmd_nack,     // Refused pulse
  output logic [15:0]                   cmd_rdata,
  // Limits and analog status pins
  input  wire logic [15:0]              amps_limit,
  input  wire logic [15:0]              volts_limit,
  input  wire logic [3:0]               sensor_flags, // ur,hot,cold,or
  input  wire logic                     ratio_high,
  input  wire logic                     battery_present,
  input  wire logic                     adapter_power_ok_flag,
  // Outputs to the charger
  output logic                          charge_enable,
  output logic [15:0]                   amps_setpoint,
  output logic [15:0]                   volts_setpoint,
  output logic                          amps_max_safe,
  output logic                          volts_max,
  output logic                          attention_request_n
);
  import charger_pkg::*;

  // ************************************************************
  // Pin synchronisers: three stages, change once stages 2 and 3 agree
  // ************************************************************
  logic [6:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_r;
  wire  [6:0] pin_raw = {adapter_power_ok_flag, battery_present, ratio_high, sensor_flags};
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_r <= 7'h00;
      pin_s2_r <= 7'h00;
      pin_s3_r <= 7'h00;
      pin_r    <= 7'h00;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_r    <= (pin_s2_r & pin_s3_r) | (pin_r & (pin_s2_r | pin_s3_r));
    end
  end
  wire adapter_ok = pin_r[6];
  wire battery_ok = pin_r[5];

  // ************************************************************
  // Command decode
  // ************************************************************
  function automatic logic is_code(input logic [7:0] c, input logic [7:0] k);
    is_code = (c == k);
  endfunction
  wire hit_mode  = is_code(cmd_code, MODE_COMMAND);
  wire hit_stat  = is_code(cmd_code, STATUS_COMMAND);
  wire hit_amps  = is_code(cmd_code, AMPS_REQUEST_COMMAND);
  wire hit_volts = is_code(cmd_code, VOLTS_REQUEST_COMMAND);
  wire hit_alarm = is_code(cmd_code, ALARM_COMMAND);
  wire wo_hit    = hit_mode | hit_amps | hit_volts | hit_alarm;
  wire wr_ok     = cmd_wr & wo_hit;
  wire rd_ok     = cmd_rd & hit_stat;
  wire refuse    = (cmd_wr & ~wo_hit) | (cmd_rd & ~hit_stat);
  wire mode_wr   = wr_ok & hit_mode;
  // Only bits 3:0 act; upper bits dropped
  wire [3:0] mode_bits = cmd_wdata[MODE_ZERO_BIT:0];
  wire por_wr    = mode_wr & mode_bits[MODE_POR_BIT];
  wire zero_wr   = mode_wr & mode_bits[MODE_ZERO_BIT];
  wire alarm_stop = wr_ok & hit_alarm & (|cmd_wdata[15:ALARM_STOP_LO]);
  wire lost_power = ~adapter_ok | ~battery_ok;

  // ************************************************************
  // Mode inhibit bit
  // ************************************************************
  logic inhibit_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) inhibit_r <= 1'b0;
    else if (por_wr || lost_power) inhibit_r <= 1'b0;
    else if (mode_wr) inhibit_r <= mode_bits[MODE_INHIBIT_BIT];
  end

  // ************************************************************
  // Request pairing: a current and voltage within the window
  // ************************************************************
  logic        have_amps_r, have_volts_r;
  logic [15:0] amps_req_r, volts_req_r;
  logic [39:0] pair_cnt_r; // Three minutes of cycles overflows 32 bits
  wire amps_wr   = wr_ok & hit_amps;
  wire volts_wr  = wr_ok & hit_volts;
  wire win_out   = pair_cnt_r >= 40'(PAIR_WINDOW);
  wire got_amps  = have_amps_r | amps_wr;
  wire got_volts = have_volts_r | volts_wr;
  wire pair_done = got_amps & got_volts & (amps_wr | volts_wr) & ~win_out;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      have_amps_r  <= 1'b0;
      have_volts_r <= 1'b0;
      amps_req_r   <= WORD_RESET;
      volts_req_r  <= WORD_RESET;
      pair_cnt_r   <= 40'h0;
    end else begin
      if (pair_done || win_out || zero_wr) begin
        have_amps_r  <= 1'b0;
        have_volts_r <= 1'b0;
        pair_cnt_r   <= 40'h0;
      end else begin
        have_amps_r  <= got_amps;
        have_volts_r <= got_volts;
        if (amps_wr || volts_wr) pair_cnt_r <= 40'h0;
        else if (have_amps_r || have_volts_r) pair_cnt_r <= pair_cnt_r + 40'h1;
      end
      if (amps_wr) amps_req_r <= cmd_wdata;
      if (volts_wr) volts_req_r <= cmd_wdata;
    end
  end
  wire [15:0] amps_new  = amps_wr ? cmd_wdata : amps_req_r;
  wire [15:0] volts_new = volts_wr ? cmd_wdata : volts_req_r;

  // ************************************************************
  // Limit check and substitution
  // ************************************************************
  wire amps_ones  = amps_new == REQ_ALL_ONES;
  wire volts_ones = volts_new == REQ_ALL_ONES;
  wire amps_over  = ~amps_ones & (amps_new > amps_limit);
  wire volts_over = ~volts_ones & (volts_new > volts_limit);
  wire [15:0] amps_use  = amps_over ? amps_limit : amps_new;
  wire [15:0] volts_use = volts_over ? volts_limit : volts_new;

  // Setpoint store, never written (write enable tied low); zeroing clears it
  logic [15:0] store_rd_unused;
  request_store u_store (
    .clock   (clock),
    .rst_b   (rst_b),
    .wr_en   (1'b0),
    .wr_sel  (1'b0),
    .wr_data (WORD_RESET),
    .clr     (zero_wr),
    .rd_sel  (1'b0),
    .rd_data (store_rd_unused)
  );

  logic amps_or_r, volts_or_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      amps_setpoint  <= WORD_RESET;
      volts_setpoint <= WORD_RESET;
      amps_max_safe  <= 1'b0;
      volts_max      <= 1'b0;
      amps_or_r      <= 1'b0;
      volts_or_r     <= 1'b0;
    end else if (zero_wr) begin
      amps_setpoint  <= WORD_RESET;
      volts_setpoint <= WORD_RESET;
      amps_max_safe  <= 1'b0;
      volts_max      <= 1'b0;
    end else if (pair_done) begin
      amps_setpoint  <= amps_use;
      volts_setpoint <= volts_use;
      amps_max_safe  <= amps_ones;
      volts_max      <= volts_ones;
      amps_or_r      <= amps_over;
      volts_or_r     <= volts_over;
    end
  end

  // ************************************************************
  // Charger state and alarm inhibit
  // ************************************************************
  chg_state_t state_r, state_nxt;
  logic       alarm_inh_r;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CHG_NONE: begin
        // One half seen: wait for its partner
        if (pair_done) state_nxt = CHG_RUN;
        else if (amps_wr || volts_wr) state_nxt = CHG_WAIT;
      end
      CHG_WAIT: begin
        // Partner never came inside the window
        if (pair_done) state_nxt = CHG_RUN;
        else if (win_out) state_nxt = CHG_NONE;
      end
      CHG_RUN:  if (zero_wr || alarm_stop || lost_power) state_nxt = CHG_NONE;
      default:  state_nxt = CHG_NONE;
    endcase
    if (zero_wr) state_nxt = CHG_NONE;
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r     <= CHG_NONE;
      alarm_inh_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (alarm_stop) alarm_inh_r <= 1'b1;
      else if (por_wr || lost_power || pair_done) alarm_inh_r <= 1'b0;
    end
  end
  wire sensor_bad = pin_r[0] | pin_r[1] | pin_r[2] | pin_r[3];
  wire run_ok = (state_r == CHG_RUN) & ~inhibit_r & ~alarm_inh_r & ~sensor_bad;

  // ************************************************************
  // Status word, assembled from live flags
  // ************************************************************
  wire [15:0] status_word = {adapter_ok, battery_ok, pin_r[4], alarm_inh_r,
                             pin_r[3:0],
                             volts_or_r, amps_or_r, ST_LEVEL_VAL,
                             1'b0, 1'b0, 1'b0,
                             inhibit_r};

  // ************************************************************
  // Attention request on status change
  // ************************************************************
  logic [15:0] status_seen_r;
  logic        attn_r;
  wire         changed = status_word != status_seen_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      status_seen_r <= {10'h000, ST_LEVEL_VAL, 4'h0}; // Resting status: no false change
      attn_r        <= 1'b0;
    end else begin
      status_seen_r <= status_word;
      if (changed) attn_r <= 1'b1;
      else if (rd_ok || ara_rd) attn_r <= 1'b0;
    end
  end

  // ************************************************************
  // Answer registers
  // ************************************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cmd_ack             <= 1'b0;
      cmd_nack            <= 1'b0;
      cmd_rdata           <= WORD_RESET;
      charge_enable       <= 1'b0;
      attention_request_n <= 1'b1;
    end else begin
      cmd_ack             <= wr_ok | rd_ok;
      cmd_nack            <= refuse;
      if (rd_ok) cmd_rdata <= status_word;
      charge_enable       <= run_ok & ~alarm_stop & ~zero_wr;
      attention_request_n <= ~(attn_r | changed);
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  a_read_refused: assert property (@(posedge clock) disable iff (!rst_b)
    (cmd_rd && wo_hit) |=> cmd_nack && !cmd_ack) else $error("write-only read not refused");
  a_write_refused: assert property (@(posedge clock) disable iff (!rst_b)
    (cmd_wr && hit_stat) |=> cmd_nack) else $error("status write not refused");
  a_status_fixed: assert property (@(posedge clock) disable iff (!rst_b)
    rd_ok |=> cmd_rdata[5:0] == {ST_LEVEL_VAL, 3'b000, $past(inhibit_r)})
    else $error("status fixed bits wrong");
  a_zero_stops: assert property (@(posedge clock) disable iff (!rst_b)
    zero_wr |=> !charge_enable ##1 !charge_enable) else $error("zeroing did not stop");
  a_alarm_stops: assert property (@(posedge clock) disable iff (!rst_b)
    alarm_stop |=> !charge_enable && alarm_inh_r) else $error("alarm did not stop");
  a_alarm_zero: assert property (@(posedge clock) disable iff (!rst_b)
    (wr_ok && hit_alarm && cmd_wdata[15:12] == 4'h0 && state_r == CHG_RUN && !lost_power)
    |=> state_r == CHG_RUN) else $error("zero alarm acted");
  a_amps_clamp: assert property (@(posedge clock) disable iff (!rst_b)
    (pair_done && !zero_wr && amps_over) |=> amps_setpoint == $past(amps_limit) && amps_or_r)
    else $error("current not clamped");
  a_volts_clamp: assert property (@(posedge clock) disable iff (!rst_b)
    (pair_done && !zero_wr && volts_over) |=> volts_setpoint == $past(volts_limit))
    else $error("voltage not clamped");
  a_inhibit_clear: assert property (@(posedge clock) disable iff (!rst_b)
    (por_wr || lost_power) |=> !inhibit_r) else $error("inhibit not cleared");
  a_attn_change: assert property (@(posedge clock) disable iff (!rst_b)
    changed |=> !attention_request_n) else $error("attention not raised");
  c_pair_run: cover property (@(posedge clock) disable iff (!rst_b) pair_done ##1 state_r == CHG_RUN);
  c_alarm: cover property (@(posedge clock) disable iff (!rst_b) alarm_stop);
  c_status_rd: cover property (@(posedge clock) disable iff (!rst_b) rd_ok ##1 cmd_ack);
  c_half_stale: cover property (@(posedge clock) disable iff (!rst_b)
    state_r == CHG_WAIT ##1 state_r == CHG_NONE);
endmodule
`default_nettype wire

// >>> dv/cmd_host_model.sv
// Stand-in for the bus protocol engine that issues word commands into the bank
`timescale 1ns/1ps
`default_nettype none
module cmd_host_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Command port toward the bank
  output logic             cmd_wr,
  output logic             cmd_rd,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata,
  output logic             ara_rd,
  input  wire logic        cmd_ack,
  input  wire logic        cmd_nack,
  input  wire logic [15:0] cmd_rdata
);
  logic timed_out; // Set when an answer never came

  // Idle levels from time zero
  initial begin
    cmd_wr    = 1'b0;
    cmd_rd    = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
    ara_rd    = 1'b0;
    timed_out = 1'b0;
  end

  // ************************************************************
  // One word transfer, a single-edge pulse then a bounded wait
  // ************************************************************
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                      output logic ack, output logic nack, output logic [15:0] rd);
    int i;
    @(posedge clock) #1;
    cmd_wr    = wr;
    cmd_rd    = ~wr;
    cmd_code  = code;
    cmd_wdata = data;
    @(posedge clock) #1;
    cmd_wr    = 1'b0;
    cmd_rd    = 1'b0;
    // Released lines show the inverse, so a stale capture cannot pass
    cmd_code  = ~code;
    cmd_wdata = ~data;
    for (i = 0; i < 8 && !(cmd_ack === 1'b1 || cmd_nack === 1'b1); i++) @(posedge clock) #1;
    ack  = cmd_ack;
    nack = cmd_nack;
    rd   = cmd_rdata;
    if (i == 8) timed_out = 1'b1;
  endtask

  // Alert response read completed on the bus
  task automatic ara_pulse();
    @(posedge clock) #1;
    ara_rd = 1'b1;
    @(posedge clock) #1;
    ara_rd = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> dv/charger_command_word_bank_bench.sv
// Self-checking bench for the charger command word bank
`timescale 1ns/1ps
`default_nettype none
module charger_command_word_bank_bench;
  import charger_pkg::*;
  localparam longint PW = 100; // Short pairing window keeps the run brief
  logic clock, rst_b, cmd_wr, cmd_rd, ara_rd, cmd_ack, cmd_nack;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, alim, vlim, amps_setpoint, volts_setpoint, r;
  logic [3:0]  sensor;
  logic ratio, batt, adapt, charge_enable, amps_max_safe, volts_max, attention_request_n;
  logic inh, aor, vor, alm;         // Expected sticky status flags
  logic [7:0] ro_codes [4];          // Write-only command codes
  int mismatches, check_count, seed;

  cmd_host_model host (.clock(clock), .rst_b(rst_b), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .ara_rd(ara_rd), .cmd_ack(cmd_ack),
    .cmd_nack(cmd_nack), .cmd_rdata(cmd_rdata));
  charger_command_word_bank #(.PAIR_WINDOW(PW)) dut (.clock(clock), .rst_b(rst_b),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .ara_rd(ara_rd), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack), .cmd_rdata(cmd_rdata),
    .amps_limit(alim), .volts_limit(vlim), .sensor_flags(sensor), .ratio_high(ratio),
    .battery_present(batt), .adapter_power_ok_flag(adapt), .charge_enable(charge_enable),
    .amps_setpoint(amps_setpoint), .volts_setpoint(volts_setpoint),
    .amps_max_safe(amps_max_safe), .volts_max(volts_max),
    .attention_request_n(attention_request_n));

  // Free-running 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ************************************************************
  // Checking and expectation helpers
  // ************************************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock) #1;
  endtask

  // Clamp to the programmed maximum
  function automatic logic [15:0] clamp(input logic [15:0] q, input logic [15:0] lim);
    return (q > lim) ? lim : q;
  endfunction

  // Status word as the pins and sticky flags say it must read
  function automatic logic [15:0] status_exp();
    return {adapt, batt, ratio, alm, sensor, vor, aor, ST_LEVEL_VAL, 3'b000, inh};
  endfunction

  // One command with its expected answer; a lost answer ends the run
  task automatic do_x(input logic wr, input logic [7:0] code, input logic [15:0] data,
                      input logic exp_ack, output logic [15:0] rd);
    logic ack;
    logic nack;
    host.xfer(wr, code, data, ack, nack, rd);
    if (host.timed_out === 1'b1) begin
      mismatches++;
      final_report();
    end else begin
      check({14'h0, ack, nack}, {14'h0, exp_ack, ~exp_ack});
    end
  endtask

  task automatic rd_status();
    do_x(1'b0, STATUS_COMMAND, 16'h0000, 1'b1, r);
    check(r, status_exp());
  endtask

  // Current and voltage pair in either order, then the charger outputs
  task automatic pair(input logic [15:0] a, input logic [15:0] v, input logic vfirst);
    if (vfirst) do_x(1'b1, VOLTS_REQUEST_COMMAND, v, 1'b1, r);
    do_x(1'b1, AMPS_REQUEST_COMMAND, a, 1'b1, r);
    if (!vfirst) do_x(1'b1, VOLTS_REQUEST_COMMAND, v, 1'b1, r);
    cyc(2);
    aor = (a != REQ_ALL_ONES) && (a > alim);
    vor = (v != REQ_ALL_ONES) && (v > vlim);
    alm = 1'b0;
    if (a != REQ_ALL_ONES) check(amps_setpoint, clamp(a, alim));
    if (v != REQ_ALL_ONES) check(volts_setpoint, clamp(v, vlim));
    check(16'(amps_max_safe), 16'(a == REQ_ALL_ONES));
    check(16'(volts_max), 16'(v == REQ_ALL_ONES));
    check(16'(charge_enable), 16'h0001);
  endtask

  function automatic logic [15:0] pick(input logic over, input logic [15:0] lim);
    return over ? lim + 16'h0001 + 16'($urandom_range(0, 4096)) : 16'($urandom_range(0, lim));
  endfunction

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {sensor, ratio, batt, adapt, inh, aor, vor, alm} = 11'h000;
    alim = 16'h0800;
    vlim = 16'h0800;
    ro_codes = '{MODE_COMMAND, AMPS_REQUEST_COMMAND, VOLTS_REQUEST_COMMAND, ALARM_COMMAND};
    rst_b = 1'b0;
    repeat (10) @(posedge clock);
    #1 rst_b = 1'b1;
    seed = $urandom(79);
    check(cmd_rdata, WORD_RESET);
    check(amps_setpoint | volts_setpoint, 16'h0000);
    check(16'({charge_enable, attention_request_n}), 16'h0001);
    alim = 16'h0800 + 16'($urandom_range(0, 16'h3000));
    vlim = 16'h0800 + 16'($urandom_range(0, 16'h3000));
    {batt, adapt} = 2'b11;
    // Sensor decode corners, then random pin patterns
    for (int k = 0; k < 8; k++) begin
      // Never all clear, so the return to zero below is a real change
      sensor = (k < 4) ? 4'h1 << k : 4'($urandom_range(1, 15));
      ratio  = 1'($urandom_range(0, 1));
      cyc(6);
      rd_status();
    end
    {sensor, ratio} = 5'h00;
    cyc(6);
    check(16'(attention_request_n), 16'h0000);
    rd_status();
    cyc(1);
    check(16'(attention_request_n), 16'h0001);
    ratio = 1'b1;
    cyc(6);
    check(16'(attention_request_n), 16'h0000);
    host.ara_pulse();
    cyc(1);
    check(16'(attention_request_n), 16'h0001);
    // Refused directions
    foreach (ro_codes[i]) do_x(1'b0, ro_codes[i], 16'h0000, 1'b0, r);
    do_x(1'b1, STATUS_COMMAND, 16'($urandom), 1'b0, r);
    rd_status();
    // Pairs at the limit, below it and above it, both orders
    for (int k = 0; k < 6; k++) begin
      pair((k == 0) ? alim : pick(k[0], alim), (k == 0) ? vlim : pick(k[1], vlim), k[0] ^ k[1]);
      rd_status();
    end
    pair(REQ_ALL_ONES, 16'h0100, 1'b0);
    pair(16'h0100, REQ_ALL_ONES, 1'b1);
    // Zeroing stops charging; one half alone does not restart, a stale half is dropped
    do_x(1'b1, MODE_COMMAND, 16'h0008, 1'b1, r);
    cyc(2);
    check(16'(charge_enable), 16'h0000);
    do_x(1'b1, AMPS_REQUEST_COMMAND, 16'h0100, 1'b1, r);
    cyc(int'(PW) + 10);
    do_x(1'b1, VOLTS_REQUEST_COMMAND, 16'h0200, 1'b1, r);
    cyc(2);
    check(16'(charge_enable), 16'h0000);
    do_x(1'b1, AMPS_REQUEST_COMMAND, 16'h0100, 1'b1, r);
    cyc(2);
    check(16'(charge_enable), 16'h0001);
    {aor, vor} = 2'b00;
    // Upper mode bits carry no function
    do_x(1'b1, MODE_COMMAND, {12'($urandom), 4'h0}, 1'b1, r);
    cyc(2);
    check(16'(charge_enable), 16'h0001);
    rd_status();
    // Each stop alarm bit, after a write of zeros in the stop field
    for (int b = ALARM_STOP_LO; b < 16; b++) begin
      pair(16'h0100, 16'h0200, 1'b0);
      do_x(1'b1, ALARM_COMMAND, 16'h0fff, 1'b1, r);
      cyc(2);
      check(16'(charge_enable), 16'h0001);
      do_x(1'b1, ALARM_COMMAND, (16'h0001 << b) | 16'($urandom_range(0, 16'h0fff)), 1'b1, r);
      alm = 1'b1;
      cyc(2);
      check(16'(charge_enable), 16'h0000);
      rd_status();
    end
    pair(16'h0100, 16'h0200, 1'b1);
    rd_status();
    // Inhibit, then its clearing by the mode reset bit and by power or battery loss
    do_x(1'b1, MODE_COMMAND, 16'h0001, 1'b1, r);
    inh = 1'b1;
    cyc(3);
    check(16'(charge_enable), 16'h0000);
    rd_status();
    do_x(1'b1, MODE_COMMAND, 16'h0004, 1'b1, r);
    inh = 1'b0;
    rd_status();
    for (int j = 0; j < 2; j++) begin
      do_x(1'b1, ALARM_COMMAND, 16'h8000, 1'b1, r);
      do_x(1'b1, MODE_COMMAND, 16'h0001, 1'b1, r);
      {inh, alm} = 2'b11;
      rd_status();
      if (j == 0) batt = 1'b0;
      else adapt = 1'b0;
      cyc(6);
      {inh, alm} = 2'b00;
      rd_status();
      {batt, adapt} = 2'b11;
      cyc(6);
    end
    final_report();
  end
endmodule
`default_nettype wire
